// File: ebus_pkg.sv
`default_nettype none
package ebus_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MIN_TRANSITION_PS = 12500;
	localparam int HALF_STEP_CYCLES = (MIN_TRANSITION_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STEP_CYCLES = 2 * HALF_STEP_CYCLES;
	localparam int CS_COUNT = 2;

	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_TIMING0 = 4'h1;
	localparam logic [3:0] REG_TIMING1 = 4'h2;
	localparam logic [3:0] REG_WINDOW = 4'h3;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_WDATA = 4'h5;
	localparam logic [3:0] REG_CMD = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_RDATA = 4'h8;

	localparam int CTRL_MUX_BIT = 0;
	localparam int CTRL_RDY_EN_BIT = 1;
	localparam int CTRL_RDY_HIGH_BIT = 2;
	localparam int CTRL_RDY_ASYNC_BIT = 3;
	localparam int CTRL_BUS_REFERENCE_CLOCK_OUT_BIT = 4;
	localparam int CMD_READ_BIT = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam int STATUS_CS_BIT = 2;

	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [13:0] TIMING_RESET = 14'h3fff;
	localparam logic [7:0] WINDOW_RESET = 8'h80;

	// address setup and access fields hold length minus one
	typedef struct packed {
		logic [1:0] hold_phase_length;
		logic [4:0] access_phase_length;
		logic data_setup_tristate_length;
		logic [1:0] command_delay_length;
		logic [1:0] window_change_extra;
		logic [1:0] address_setup_length;
	} chip_select_timing_config_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CMD = 3'b011,
		ST_DSET = 3'b010,
		ST_ACC = 3'b110,
		ST_RDYW = 3'b111,
		ST_HOLD = 3'b101
	} bus_phase_t;
endpackage
`default_nettype wire

// File: ebus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ebus_if;
	logic tick;
	logic half_high;
	logic ready_async;
	logic ready_high;
	logic ready_active;
	modport timer (output tick, output half_high);
	modport ready (input ready_async, input ready_high, output ready_active);
	modport ctl (input tick, input half_high, input ready_active, output ready_async,
		output ready_high);
endinterface
`default_nettype wire

// File: step_timer.sv
`timescale 1ns/1ps
`default_nettype none
module step_timer import ebus_pkg::*; #(
	parameter int STEPS = STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	ebus_if.timer link
);
	logic [3:0] cyc;
	logic [3:0] next_cyc;

	if (STEPS < 2 || STEPS > 15 || (STEPS % 2) != 0) begin : g_bad_steps
		$error("step_timer: STEPS must be even and within 2..14");
	end

	assign next_cyc = (cyc == 4'(STEPS - 1)) ? 4'h0 : cyc + 4'h1;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cyc <= 4'h0;
		end else begin
			cyc <= next_cyc;
		end
	end

	// tick marks the first cycle of each timing step
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			link.tick <= 1'b0;
			link.half_high <= 1'b0;
		end else begin
			link.tick <= (next_cyc == 4'h0);
			link.half_high <= (next_cyc < 4'(STEPS / 2));
		end
	end
endmodule // step_timer
`default_nettype wire

// File: ready_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module ready_sampler (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ready_in,
	ebus_if.ready link
);
	logic meta;
	logic sync;
	logic extra;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta <= 1'b0;
			sync <= 1'b0;
			extra <= 1'b0;
		end else begin
			meta <= ready_in;
			sync <= meta;
			extra <= sync;
		end
	end

	// extra stage in async mode trades one wait state for safe sampling
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			link.ready_active <= 1'b0;
		end else begin
			link.ready_active <= ((link.ready_async ? extra : sync) == link.ready_high);
		end
	end
endmodule // ready_sampler
`default_nettype wire

// File: external_bus_controller.sv
// Overview of operation
// - five phases in fixed order per cycle
// - phase lengths from per chip select config
// - address setup 1..4 steps, +0..3 on window change
// - command delay 0..3, data setup 0..1 steps
// - access 1..32 steps, ready may extend
// - hold phase 0..3 steps
// - read data captured as read strobe rises
// - address change must not disturb reads
// - bus transitions at least 12.5 ns apart
// - reference clock driven out, one period per step
// - multiplexed shared lines or separate address/data buses
// - ready polarity selectable, sync or async sampling
// - inactive ready adds wait, active ends cycle
`timescale 1ns/1ps
`default_nettype none
module external_bus_controller import ebus_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [CS_COUNT-1:0] chip_select_n,
	output logic address_latch_enable,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic upper_byte_enable_n,
	output logic [23:0] address_lines,
	input wire logic [15:0] data_lines_in,
	output logic [15:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic [15:0] shared_address_data_lines_in,
	output logic [15:0] shared_address_data_lines_out,
	output logic shared_address_data_lines_oe,
	input wire logic ready_in,
	output logic bus_reference_clock_out
);
	ebus_if bus_if ();

	logic [4:0] ctrl;
	chip_select_timing_config_t timing [CS_COUNT];
	logic [7:0] window_base;
	logic [23:0] req_addr;
	logic [15:0] req_wdata;
	logic [15:0] rdata;
	logic done;
	logic pending;
	logic is_write;
	logic cur_cs;
	logic last_cs;
	logic cs_known;
	bus_phase_t state;
	bus_phase_t next_state;
	logic [5:0] rem;
	logic [5:0] next_rem;
	logic [15:0] data_meta;
	logic [15:0] data_sync;
	logic [15:0] shared_meta;
	logic [15:0] shared_sync;
	logic [31:0] rd_word;
	logic [31:0] merged;
	logic wr_en;
	logic busy;
	logic sel_cs;
	logic next_cs;
	logic leaving_access;
	chip_select_timing_config_t cfg;
	chip_select_timing_config_t sel_cfg;

	step_timer u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.link(bus_if.timer)
	);

	ready_sampler u_ready (
		.ref_clk(ref_clk),
		.rst(rst),
		.ready_in(ready_in),
		.link(bus_if.ready)
	);

	assign bus_if.ready_async = ctrl[CTRL_RDY_ASYNC_BIT];
	assign bus_if.ready_high = ctrl[CTRL_RDY_HIGH_BIT];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// first phase at or after s that has a non-zero length
	function automatic bus_phase_t skip_empty(input bus_phase_t s,
		input chip_select_timing_config_t c);
		bus_phase_t r;
		r = s;
		if (r == ST_CMD && c.command_delay_length == 2'h0) begin
			r = ST_DSET;
		end
		if (r == ST_DSET && !c.data_setup_tristate_length) begin
			r = ST_ACC;
		end
		if (r == ST_HOLD && c.hold_phase_length == 2'h0) begin
			r = ST_IDLE;
		end
		return r;
	endfunction

	function automatic logic [5:0] phase_len(input bus_phase_t s,
		input chip_select_timing_config_t c);
		case (s)
			ST_CMD: phase_len = {4'h0, c.command_delay_length};
			ST_DSET: phase_len = {5'h00, c.data_setup_tristate_length};
			ST_ACC: phase_len = {1'b0, c.access_phase_length} + 6'h01;
			ST_HOLD: phase_len = {4'h0, c.hold_phase_length};
			default: phase_len = 6'h01;
		endcase
	endfunction

	// register bus: one wait cycle, then the request is taken
	assign wr_en = avs_write && !avs_waitrequest;
	assign busy = pending || (state != ST_IDLE);
	assign merged = merge(rd_word, avs_writedata, avs_byteenable);

	always_comb begin
		rd_word = '0;
		if (avs_address == REG_CTRL) begin
			rd_word[4:0] = ctrl;
		end else if (avs_address == REG_TIMING0) begin
			rd_word[13:0] = timing[0];
		end else if (avs_address == REG_TIMING1) begin
			rd_word[13:0] = timing[1];
		end else if (avs_address == REG_WINDOW) begin
			rd_word[7:0] = window_base;
		end else if (avs_address == REG_ADDR) begin
			rd_word[23:0] = req_addr;
		end else if (avs_address == REG_WDATA) begin
			rd_word[15:0] = req_wdata;
		end else if (avs_address == REG_STATUS) begin
			rd_word[STATUS_BUSY_BIT] = busy;
			rd_word[STATUS_DONE_BIT] = done;
			rd_word[STATUS_CS_BIT] = last_cs;
		end else if (avs_address == REG_RDATA) begin
			rd_word[15:0] = rdata;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_word;
		end
	end

	// timing is not locked while busy: software must not retune a live cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			timing[0] <= TIMING_RESET;
			timing[1] <= TIMING_RESET;
			window_base <= WINDOW_RESET;
			req_addr <= '0;
			req_wdata <= '0;
		end else if (wr_en) begin
			if (avs_address == REG_CTRL) begin
				ctrl <= merged[4:0];
			end else if (avs_address == REG_TIMING0) begin
				timing[0] <= merged[13:0];
			end else if (avs_address == REG_TIMING1) begin
				timing[1] <= merged[13:0];
			end else if (avs_address == REG_WINDOW) begin
				window_base <= merged[7:0];
			end else if (avs_address == REG_ADDR && !busy) begin
				req_addr <= merged[23:0];
			end else if (avs_address == REG_WDATA && !busy) begin
				req_wdata <= merged[15:0];
			end
		end
	end

	// data pin inputs pass two flip-flops before use
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_meta <= '0;
			data_sync <= '0;
			shared_meta <= '0;
			shared_sync <= '0;
		end else begin
			data_meta <= data_lines_in;
			data_sync <= data_meta;
			shared_meta <= shared_address_data_lines_in;
			shared_sync <= shared_meta;
		end
	end

	assign sel_cs = (req_addr[23:16] >= window_base);
	assign sel_cfg = timing[sel_cs];
	assign cfg = timing[cur_cs];
	assign next_cs = (state == ST_IDLE) ? sel_cs : cur_cs;
	assign leaving_access = (state == ST_ACC || state == ST_RDYW) &&
		!(next_state == ST_ACC || next_state == ST_RDYW);

	// phases only advance on step boundaries, so every phase-driven pin change is a step apart
	always_comb begin
		next_state = state;
		next_rem = rem;
		if (bus_if.tick) begin
			case (state)
				ST_IDLE: begin
					if (pending) begin
						next_state = ST_ADDR;
						next_rem = {4'h0, sel_cfg.address_setup_length} + 6'h01;
						if (!cs_known || sel_cs != last_cs) begin
							next_rem = next_rem + {4'h0, sel_cfg.window_change_extra};
						end
					end
				end
				ST_ADDR, ST_CMD, ST_DSET, ST_HOLD: begin
					if (rem > 6'h01) begin
						next_rem = rem - 6'h01;
					end else begin
						case (state)
							ST_ADDR: next_state = skip_empty(ST_CMD, cfg);
							ST_CMD: next_state = skip_empty(ST_DSET, cfg);
							ST_DSET: next_state = ST_ACC;
							default: next_state = ST_IDLE;
						endcase
						next_rem = phase_len(next_state, cfg);
					end
				end
				ST_ACC: begin
					if (rem > 6'h01) begin
						next_rem = rem - 6'h01;
					end else if (ctrl[CTRL_RDY_EN_BIT] &&
						(ctrl[CTRL_RDY_ASYNC_BIT] || !bus_if.ready_active)) begin
						next_state = ST_RDYW;
						next_rem = 6'h01;
					end else begin
						next_state = skip_empty(ST_HOLD, cfg);
						next_rem = phase_len(next_state, cfg);
					end
				end
				ST_RDYW: begin
					if (bus_if.ready_active) begin
						next_state = skip_empty(ST_HOLD, cfg);
						next_rem = phase_len(next_state, cfg);
					end
				end
				default: begin
					next_state = ST_IDLE;
					next_rem = 6'h01;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			rem <= 6'h01;
			cur_cs <= 1'b0;
			is_write <= 1'b0;
		end else begin
			state <= next_state;
			rem <= next_rem;
			cur_cs <= next_cs;
			if (wr_en && avs_address == REG_CMD && !busy) begin
				is_write <= merged[CMD_WRITE_BIT];
			end
		end
	end

	// a new request in the cycle that ends the old one sees busy and is ignored
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pending <= 1'b0;
			done <= 1'b0;
			last_cs <= 1'b0;
			cs_known <= 1'b0;
		end else begin
			if (wr_en && avs_address == REG_CMD && !busy &&
				(merged[CMD_READ_BIT] || merged[CMD_WRITE_BIT])) begin
				pending <= 1'b1;
			end else if (state == ST_IDLE && next_state == ST_ADDR) begin
				pending <= 1'b0;
				last_cs <= sel_cs;
				cs_known <= 1'b1;
			end
			if (state != ST_IDLE && next_state == ST_IDLE) begin
				done <= 1'b1;
			end else if (wr_en && avs_address == REG_STATUS && merged[STATUS_DONE_BIT]) begin
				done <= 1'b0;
			end
		end
	end

	// read data latched on the edge that raises the read strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (leaving_access && !is_write) begin
			rdata <= ctrl[CTRL_MUX_BIT] ? shared_sync : data_sync;
		end
	end

	// pins are registered from the next phase so they move with the state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chip_select_n <= '1;
			address_latch_enable <= 1'b0;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			upper_byte_enable_n <= 1'b1;
		end else begin
			for (int i = 0; i < CS_COUNT; i++) begin
				chip_select_n[i] <= !(next_state != ST_IDLE && next_cs == 1'(i));
			end
			address_latch_enable <= ctrl[CTRL_MUX_BIT] && next_state == ST_ADDR;
			read_strobe_n <= !(!is_write && (next_state == ST_ACC || next_state == ST_RDYW));
			write_strobe_n <= !(is_write && (next_state == ST_ACC || next_state == ST_RDYW));
			upper_byte_enable_n <= (next_state == ST_IDLE);
		end
	end

	// address stays put until the next cycle, so a late change never hits a read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			address_lines <= '0;
			data_lines_out <= '0;
			data_lines_oe <= 1'b0;
			shared_address_data_lines_out <= '0;
			shared_address_data_lines_oe <= 1'b0;
		end else begin
			if (state == ST_IDLE && next_state == ST_ADDR) begin
				address_lines <= req_addr;
			end
			data_lines_out <= req_wdata;
			data_lines_oe <= !ctrl[CTRL_MUX_BIT] && is_write && (next_state == ST_DSET ||
				next_state == ST_ACC || next_state == ST_RDYW || next_state == ST_HOLD);
			if (next_state == ST_ADDR || next_state == ST_CMD) begin
				shared_address_data_lines_out <= req_addr[15:0];
				shared_address_data_lines_oe <= ctrl[CTRL_MUX_BIT];
			end else begin
				shared_address_data_lines_out <= req_wdata;
				shared_address_data_lines_oe <= ctrl[CTRL_MUX_BIT] && is_write &&
					next_state != ST_IDLE;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_reference_clock_out <= 1'b0;
		end else begin
			bus_reference_clock_out <= ctrl[CTRL_BUS_REFERENCE_CLOCK_OUT_BIT] && bus_if.half_high;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_phase_order: assert property ($changed(state) && state == ST_ACC |->
		$past(state) inside {ST_ADDR, ST_CMD, ST_DSET}) else $error("access entered out of order");
	a_step_aligned: assert property ($changed(state) |-> $past(bus_if.tick))
		else $error("phase changed off a step boundary");
	a_setup_length: assert property ($rose(state == ST_ADDR) |-> rem inside {[1:5]})
		else $error("address setup length out of range");
	a_cmd_length: assert property ($rose(state == ST_CMD) |-> rem inside {[1:3]})
		else $error("command delay length out of range");
	a_access_length: assert property ($rose(state == ST_ACC) |-> rem inside {[1:32]})
		else $error("access length out of range");
	a_hold_length: assert property ($rose(state == ST_HOLD) |-> rem inside {[1:3]})
		else $error("hold length out of range");
	a_read_latch: assert property (leaving_access && !is_write |=> $rose(read_strobe_n) &&
		rdata == $past(ctrl[CTRL_MUX_BIT] ? shared_sync : data_sync)) else $error("read latch slip");
	a_strobe_spacing: assert property ($changed(read_strobe_n) |=>
		!$changed(read_strobe_n) [*5]) else $error("read strobe toggled too soon");
	a_ready_wait: assert property (state == ST_RDYW && bus_if.tick && !bus_if.ready_active
		|=> state == ST_RDYW) else $error("cycle ended with ready inactive");
	a_ale_in_setup: assert property (address_latch_enable |-> state == ST_ADDR)
		else $error("latch enable outside address setup");
	a_cs_held: assert property (state != ST_IDLE |-> chip_select_n[cur_cs] == 1'b0)
		else $error("chip select dropped inside a cycle");

	c_read_cycle: cover property (leaving_access && !is_write);
	c_write_cycle: cover property ($rose(write_strobe_n));
	c_ready_wait: cover property (state == ST_RDYW ##1 state == ST_RDYW);
	c_window_change: cover property ($rose(state == ST_ADDR) && rem > 6'h02);
endmodule // external_bus_controller
`default_nettype wire

// File: mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
	input wire logic ref_clk,
	input wire logic [1:0] cs_n,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [23:0] addr,
	input wire logic [15:0] d_out,
	input wire logic [15:0] ad_out,
	input wire logic multiplexed_bus_mode,
	input wire logic rdy_high,
	input wire logic [3:0] rdy_wait,
	output logic [15:0] d_far,
	output logic [15:0] ad_far,
	output logic ready
);
	logic [15:0] mem [256];
	logic [7:0] idx;
	logic [3:0] cnt = 4'h0;
	logic act;
	logic rdy;
	assign act = cs_n != 2'b11;
	// active only while a strobe is low, so it drops as the strobe rises
	assign rdy = act && !(rd_n && wr_n) && cnt >= rdy_wait;
	assign ready = rdy_high ? rdy : !rdy;
	initial begin
		d_far = 16'h0000;
		ad_far = 16'h0000;
	end
	always @(posedge ref_clk) begin
		if (ale) idx <= ad_out[7:0];
		else if (!multiplexed_bus_mode && act && rd_n && wr_n) idx <= addr[7:0];
		if (act && !wr_n) mem[idx] <= multiplexed_bus_mode ? ad_out : d_out;
		if (act && !(rd_n && wr_n)) begin
			if (cnt != 4'hf) cnt <= cnt + 4'h1;
		end else cnt <= 4'h0;
		// released lines toggle so a late capture cannot pass by luck
		d_far <= (act && !rd_n && !multiplexed_bus_mode) ? mem[idx] : ~d_far;
		ad_far <= (act && !rd_n && multiplexed_bus_mode) ? mem[idx] : ~ad_far;
	end
endmodule // mem_partner
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ebus_pkg::*;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, ale, rd_n, wr_n;
	logic d_oe, ad_oe, ready_in, clk_out, multiplexed_bus_mode, rdy_high, prev_sel, first, ube_n;
	logic [3:0] avs_address, rdy_wait, be;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [1:0] cs_n;
	logic [23:0] addr_l, seen_addr;
	logic [15:0] d_in, d_out, ad_in, ad_out, d_far, ad_far, seen_ad;
	logic [15:0] shadow [256];
	logic [13:0] tm [2];
	int seed = 99787;
	int num_errors = 0;
	int n_compared = 0;
	int cs_cnt = 0, st_cnt = 0, ale_cnt = 0, cs_len, st_len, ale_len, n;
	int ube_bad = 0;
	external_bus_controller dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .chip_select_n(cs_n),
		.address_latch_enable(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.upper_byte_enable_n(ube_n), .address_lines(addr_l), .data_lines_in(d_in),
		.data_lines_out(d_out), .data_lines_oe(d_oe), .shared_address_data_lines_in(ad_in),
		.shared_address_data_lines_out(ad_out), .shared_address_data_lines_oe(ad_oe),
		.ready_in(ready_in), .bus_reference_clock_out(clk_out));
	mem_partner far (.ref_clk(ref_clk), .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr_l), .d_out(d_out), .ad_out(ad_out), .multiplexed_bus_mode(multiplexed_bus_mode), .rdy_high(rdy_high),
		.rdy_wait(rdy_wait), .d_far(d_far), .ad_far(ad_far), .ready(ready_in));
	assign d_in = d_oe ? d_out : d_far;
	assign ad_in = ad_oe ? ad_out : ad_far;
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// pin activity of one bus cycle, published when the chip selects release
	always @(posedge ref_clk) begin
		// byte enable must track the chip selects cycle for cycle
		ube_bad <= ube_bad + int'(ube_n !== (cs_n === 2'b11));
		if (cs_n !== 2'b11) begin
			cs_cnt <= cs_cnt + 1;
			st_cnt <= st_cnt + int'(!(rd_n && wr_n));
			ale_cnt <= ale_cnt + int'(ale);
			seen_addr <= addr_l;
			if (ale) seen_ad <= ad_out;
		end else if (cs_cnt != 0) begin
			cs_len <= cs_cnt;
			st_len <= st_cnt;
			ale_len <= ale_cnt;
			cs_cnt <= 0;
			st_cnt <= 0;
			ale_cnt <= 0;
		end
	end
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic int exp_access(input logic [13:0] t);
		return (int'(t[11:7]) + 1) * STEP_CYCLES;
	endfunction
	// cycles outside the strobe: setup, window extra, command delay, data setup, hold
	function automatic int exp_other(input logic [13:0] t, input logic chg);
		return (int'(t[1:0]) + 1 + int'(t[5:4]) + int'(t[6]) + int'(t[13:12]) +
			(chg ? int'(t[3:2]) : 0)) * STEP_CYCLES;
	endfunction
	// entered just after a rising edge; the answer is taken at the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			if (k++ == 20) begin
				num_errors++;
				close_out();
			end
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic op(input logic w, input logic [23:0] a, input logic [7:0] win,
			input logic ren, input logic asy);
		logic sel;
		logic [13:0] t;
		int non, e, k;
		sel = a[23:16] >= win;
		t = tm[sel];
		e = exp_access(t);
		non = exp_other(t, first || sel != prev_sel);
		first = 1'b0;
		prev_sel = sel;
		if (w) shadow[a[7:0]] = 16'($random(seed));
		bus(1'b1, REG_ADDR, {8'h00, a});
		bus(1'b1, REG_WDATA, {16'h0000, shadow[a[7:0]]});
		bus(1'b1, REG_CMD, w ? 32'h0000_0002 : 32'h0000_0001);
		bus(1'b1, REG_ADDR, {8'h00, ~a});
		q = '0;
		k = 0;
		while (q[1] !== 1'b1) begin
			if (k++ == 200) begin
				num_errors++;
				close_out();
			end
			bus(1'b0, REG_STATUS, '0);
		end
		chk("status cs", 32'(q[2]), 32'(sel));
		bus(1'b1, REG_STATUS, 32'h0000_0002);
		bus(1'b0, REG_ADDR, '0);
		chk("addr kept", q, {8'h00, a});
		chk("non-access", cs_len - st_len, non);
		if (!ren) chk("access", st_len, e);
		else chk("ready", 32'(st_len >= e + (asy ? STEP_CYCLES : 0) && st_len > rdy_wait), 1);
		chk("step grid", st_len % STEP_CYCLES, 0);
		chk("byte enable", ube_bad, 0);
		if (multiplexed_bus_mode) chk("mux addr", 32'(seen_ad), 32'(a[15:0]));
		if (multiplexed_bus_mode) chk("latch pulse", 32'(ale_len > 0), 1);
		if (!multiplexed_bus_mode) chk("addr pins", 32'(seen_addr), 32'(a));
		if (!w) bus(1'b0, REG_RDATA, '0);
		if (!w) chk("read data", q, {16'h0000, shadow[a[7:0]]});
	endtask
	initial begin
		repeat (90000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end
	initial begin
		logic [23:0] a;
		logic [7:0] win;
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		be = 4'hf;
		multiplexed_bus_mode = 1'b0;
		rdy_high = 1'b0;
		rdy_wait = 4'h0;
		first = 1'b1;
		prev_sel = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("clock idle", 32'(clk_out), 0);
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, 4'(k), '0);
			chk("reset reg", q, k == 0 ? 0 : (k == 3 ? 32'h0000_0080 : 32'h0000_3fff));
		end
		bus(1'b1, 4'h9, '1);
		bus(1'b0, 4'h9, '0);
		chk("unmapped", q, 0);
		bus(1'b0, REG_CMD, '0);
		chk("cmd reads", q, 0);
		be <= 4'h1;
		bus(1'b1, REG_TIMING1, '0);
		be <= 4'hf;
		bus(1'b0, REG_TIMING1, '0);
		chk("byte lanes", q, 32'h0000_3f00);
		for (int i = 0; i < 24; i++) begin
			a = 24'($random(seed));
			win = 8'($random(seed));
			tm[0] = 14'($random(seed)) & 14'h3ffd;
			tm[1] = 14'($random(seed)) & 14'h3ffd;
			// extremes of every phase field first, address setup only up to 2 steps
			if (i < 2) tm[0] = i == 0 ? 14'h0000 : 14'h3ffd;
			if (i < 2) win = 8'hff;
			if (i < 2) a[23] = 1'b0;
			multiplexed_bus_mode <= i[0];
			rdy_high <= i[2];
			rdy_wait <= 4'($random(seed));
			bus(1'b1, REG_TIMING0, {18'h0_0000, tm[0]});
			bus(1'b1, REG_TIMING1, {18'h0_0000, tm[1]});
			bus(1'b1, REG_WINDOW, {24'h00_0000, win});
			bus(1'b1, REG_CTRL, 32'(i & 15));
			op(1'b1, a, win, i[1], i[3]);
			op(1'b0, a, win, i[1], i[3]);
		end
		bus(1'b1, REG_CTRL, 32'h0000_0010);
		for (n = 0; n < 40 && clk_out !== 1'b1; n++) @(negedge ref_clk);
		for (n = 0; n < 40 && clk_out === 1'b1; n++) @(negedge ref_clk);
		chk("clock high", n, STEP_CYCLES / 2);
		close_out();
	end
endmodule // tb
`default_nettype wire
